// ---- rtl/scd_pkg.sv ----
package scd_pkg;

  localparam logic [7:0] OP_STATUS = 8'h40;
  localparam logic [7:0] OP_INT = 8'h46;
  localparam logic [7:0] OP_MSG_ADDR = 8'h42;
  localparam logic [7:0] OP_SECT_LEN = 8'h44;
  localparam logic [7:0] OP_IDENT = 8'h48;
  localparam logic [7:0] OP_MEM_RD = 8'hA2;
  localparam logic [7:0] OP_MEM_WR = 8'hA0;
  localparam logic [7:0] OP_RANGE_ERASE = 8'h24;
  localparam logic [7:0] OP_MASS_ERASE = 8'h26;
  localparam logic [7:0] OP_CHECKSUM = 8'hF2;
  localparam logic [7:0] OP_WAKE = 8'h10;
  localparam logic [7:0] OP_SLEEP = 8'h12;
  localparam logic [7:0] OP_CFG_WR = 8'h80;
  localparam logic [7:0] OP_CFG_RD = 8'h90;
  localparam logic [7:0] OP_MACRO = 8'hB0;
  localparam logic [7:0] OP_RECORD = 8'h38;
  localparam logic [7:0] OP_PLAY_AT = 8'h3C;
  localparam logic [7:0] OP_STOP = 8'h2A;
  localparam logic [7:0] OP_SAMPLE = 8'hAA;
  localparam logic [7:0] MASS_ERASE_KEY = 8'h01;
  localparam logic [7:0] CFG_OP_MASK = 8'hFC;

  localparam int ST_PD = 7;
  localparam int ST_RDY = 6;
  localparam int ST_INT = 5;
  localparam int ST_FULL = 4;
  localparam int ST_MACRO = 2;
  localparam int ST_QFULL = 1;
  localparam int ST_BUSY = 0;

  localparam logic [2:0] N_ADDR = 3'h3;
  localparam logic [2:0] N_RANGE = 3'h6;
  localparam logic [2:0] N_ONE = 3'h1;
  localparam logic [2:0] N_MACRO = 3'h2;
  localparam logic [2:0] N_NONE = 3'h0;
  localparam logic [2:0] CNT_MAX = 3'h7;
  localparam int CFG_IDX_W = 10;

  localparam logic PD_RESET = 1'b1;
  localparam int SCLK_HALF = 4;

  typedef enum logic [1:0] {
    S_OPCODE, S_ARGS, S_DATA, S_IGNORE
  } scd_state_type;

  typedef enum logic [1:0] {
    H_IDLE, H_SHIFT, H_NEXT, H_TAIL
  } scd_host_state_type;

endpackage

// ---- rtl/scd_spi_if.sv ----
`timescale 1ns/1ps
interface scd_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso);
endinterface

// ---- rtl/scd_spi_shifter.sv ----
`timescale 1ns/1ps
module scd_spi_shifter (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic sclk, // link clock level
  input wire logic cs_n, // frame select, active low
  input wire logic mosi, // serial data in
  input wire logic [7:0] tx_byte, // byte to send
  output logic miso, // serial data out
  output logic byte_done, // one-cycle pulse per byte
  output logic [7:0] rx_byte // last byte received
);
  logic sclk_q;
  logic [2:0] bits_q;
  logic [6:0] sh_q;

  // Bits go out MSB first; the index moves on each rising edge.
  assign miso = tx_byte[~bits_q];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      bits_q <= '0;
      sh_q <= '0;
      rx_byte <= '0;
      byte_done <= 1'b0;
    end else begin
      sclk_q <= sclk;
      byte_done <= 1'b0;
      if (cs_n) begin
        bits_q <= '0;
      end else if (sclk && !sclk_q) begin
        sh_q <= {sh_q[5:0], mosi};
        bits_q <= bits_q + 3'h1;
        if (bits_q == scd_pkg::CNT_MAX) begin
          rx_byte <= {sh_q, mosi};
          byte_done <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- rtl/scd_device.sv ----
`timescale 1ns/1ps
// Summary of operation
// - 0x40 returns status on filler bytes.
// - 0x46 returns status, clears interrupt flag.
// - 0x42 returns start address then length.
// - 0x44 returns two sector length bytes.
// - 0x48 returns identification code bytes.
// - 0xA2 plus address streams memory bytes.
// - 0xA0 plus address writes following bytes.
// - 0x24 erases sectors from start to end.
// - Mass erase needs 0x26 then 0x01.
// - 0xF2 checksums memory up to end address.
// - 0x80 configuration write, index auto-increments.
// - 0x90 configuration read, index auto-increments.
// - Refused command ignored, raises command error.
// - Status byte bit layout is fixed.
// - Record needs ready, not full, macro idle, not queued.
// - Playback needs ready, macro idle, queue free.
// - Sample send needs only power-up and ready.
// - Interrupt query accepted in every state.
module scd_device #(
  parameter logic [15:0] ID_CODE = 16'h5A3C // arbitrary value
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  scd_spi_if.device link, // serial link to host
  input wire logic buffer_ready_flag, // data buffer ready
  input wire logic memory_full_flag, // recorded memory full
  input wire logic macro_busy_flag, // voice macro busy
  input wire logic queue_full_flag, // command buffer full
  input wire logic command_busy_flag, // command busy
  input wire logic [23:0] msg_addr, // recorded message start
  input wire logic [15:0] sector_length, // current sector length
  input wire logic [7:0] mem_rdata, // memory data, after mem_re
  input wire logic [7:0] cfg_rdata, // config data, after cfg_re
  output logic powered_down_flag, // powered-down state
  output logic int_pending, // interrupt pending
  output logic cmd_err, // pulse: command refused
  output logic cmd_valid, // pulse: command issued
  output logic [7:0] cmd_code, // issued opcode
  output logic [23:0] cmd_arg_a, // address or index
  output logic [23:0] cmd_arg_b, // end address
  output logic [23:0] acc_addr, // memory or config address
  output logic [7:0] acc_wdata, // write data
  output logic mem_re, // pulse: memory read
  output logic mem_we, // pulse: memory write
  output logic cfg_re, // pulse: config read
  output logic cfg_we, // pulse: config write
  output logic sample_valid, // pulse: sample ready
  output logic [15:0] sample_data // audio sample
);
  scd_pkg::scd_state_type state_q;
  logic [7:0] op_q, snap_q, tx_q, lo_q, st, rx;
  logic [2:0] cnt_q;
  logic [39:0] arg_q;
  logic [47:0] full;
  logic [23:0] ptr_q;
  logic pd_q, int_q, phase_q, byte_done;
  logic take, refuse, args_last, in_data, bad_key, err_set;

  function automatic logic is_cfg(input logic [7:0] op);
    return (op & scd_pkg::CFG_OP_MASK) == scd_pkg::OP_CFG_WR ||
           (op & scd_pkg::CFG_OP_MASK) == scd_pkg::OP_CFG_RD;
  endfunction

  function automatic logic cfg_rd(input logic [7:0] op);
    return (op & scd_pkg::CFG_OP_MASK) == scd_pkg::OP_CFG_RD;
  endfunction

  function automatic logic [2:0] nargs(input logic [7:0] op);
    if (is_cfg(op)) return scd_pkg::N_ONE;
    case (op)
      scd_pkg::OP_MEM_RD, scd_pkg::OP_MEM_WR,
      scd_pkg::OP_CHECKSUM, scd_pkg::OP_PLAY_AT: return scd_pkg::N_ADDR;
      scd_pkg::OP_RANGE_ERASE: return scd_pkg::N_RANGE;
      scd_pkg::OP_MASS_ERASE: return scd_pkg::N_ONE;
      scd_pkg::OP_MACRO: return scd_pkg::N_MACRO;
      default: return scd_pkg::N_NONE;
    endcase
  endfunction

  function automatic logic known(input logic [7:0] op);
    return is_cfg(op) || op inside {scd_pkg::OP_STATUS, scd_pkg::OP_INT,
      scd_pkg::OP_MSG_ADDR, scd_pkg::OP_SECT_LEN, scd_pkg::OP_IDENT,
      scd_pkg::OP_MEM_RD, scd_pkg::OP_MEM_WR, scd_pkg::OP_RANGE_ERASE,
      scd_pkg::OP_MASS_ERASE, scd_pkg::OP_CHECKSUM, scd_pkg::OP_WAKE,
      scd_pkg::OP_SLEEP, scd_pkg::OP_MACRO, scd_pkg::OP_RECORD,
      scd_pkg::OP_PLAY_AT, scd_pkg::OP_STOP, scd_pkg::OP_SAMPLE};
  endfunction

  function automatic logic accept(input logic [7:0] op,
                                  input logic [7:0] s);
    logic up;
    up = !s[scd_pkg::ST_PD] && s[scd_pkg::ST_RDY];
    case (op)
      scd_pkg::OP_STATUS, scd_pkg::OP_INT, scd_pkg::OP_MSG_ADDR,
      scd_pkg::OP_SECT_LEN, scd_pkg::OP_IDENT, scd_pkg::OP_WAKE,
      scd_pkg::OP_SLEEP: return 1'b1;
      scd_pkg::OP_MACRO: return up && !s[scd_pkg::ST_MACRO] &&
        !s[scd_pkg::ST_QFULL] && !s[scd_pkg::ST_BUSY];
      scd_pkg::OP_RECORD: return up && !s[scd_pkg::ST_FULL] &&
        !s[scd_pkg::ST_MACRO] && !s[scd_pkg::ST_QFULL];
      scd_pkg::OP_PLAY_AT: return up && !s[scd_pkg::ST_MACRO] &&
        !s[scd_pkg::ST_QFULL];
      scd_pkg::OP_STOP, scd_pkg::OP_SAMPLE: return up;
      default: return !s[scd_pkg::ST_PD];
    endcase
  endfunction

  scd_spi_shifter i_scd_spi_shifter (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sclk(link.sclk),
    .cs_n(link.cs_n),
    .mosi(link.mosi),
    .tx_byte(tx_q),
    .miso(link.miso),
    .byte_done(byte_done),
    .rx_byte(rx)
  );

  always_comb begin
    st = '0;
    st[scd_pkg::ST_PD] = pd_q;
    st[scd_pkg::ST_RDY] = buffer_ready_flag;
    st[scd_pkg::ST_INT] = int_q;
    st[scd_pkg::ST_FULL] = memory_full_flag;
    st[scd_pkg::ST_MACRO] = macro_busy_flag;
    st[scd_pkg::ST_QFULL] = queue_full_flag;
    st[scd_pkg::ST_BUSY] = command_busy_flag;
  end

  assign full = {arg_q, rx};
  assign take = byte_done && state_q == scd_pkg::S_OPCODE &&
                known(rx) && accept(rx, st);
  assign refuse = byte_done && state_q == scd_pkg::S_OPCODE &&
                  known(rx) && !accept(rx, st);
  assign args_last = byte_done && state_q == scd_pkg::S_ARGS &&
                     cnt_q + 3'h1 == nargs(op_q);
  assign in_data = byte_done && state_q == scd_pkg::S_DATA;
  // only the key byte starts it
  assign bad_key = args_last && op_q == scd_pkg::OP_MASS_ERASE &&
                   rx != scd_pkg::MASS_ERASE_KEY;
  assign err_set = refuse || bad_key;
  assign powered_down_flag = pd_q;
  assign int_pending = int_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= scd_pkg::S_OPCODE;
      cnt_q <= '0;
      op_q <= '0;
      arg_q <= '0;
      snap_q <= '0;
    end else if (link.cs_n) begin
      state_q <= scd_pkg::S_OPCODE;
      cnt_q <= '0;
    end else if (byte_done) begin
      unique case (state_q)
        scd_pkg::S_OPCODE: begin
          op_q <= rx;
          cnt_q <= '0;
          snap_q <= st;
          if (!take || rx inside {scd_pkg::OP_WAKE, scd_pkg::OP_SLEEP,
              scd_pkg::OP_RECORD, scd_pkg::OP_STOP}) begin
            state_q <= scd_pkg::S_IGNORE;
          end else if (nargs(rx) != scd_pkg::N_NONE) begin
            state_q <= scd_pkg::S_ARGS;
          end else begin
            state_q <= scd_pkg::S_DATA;
          end
        end
        scd_pkg::S_ARGS: begin
          arg_q <= full[39:0];
          cnt_q <= cnt_q + 3'h1;
          if (args_last) begin
            cnt_q <= '0;
            if (op_q == scd_pkg::OP_MEM_RD || op_q == scd_pkg::OP_MEM_WR ||
                is_cfg(op_q)) begin
              state_q <= scd_pkg::S_DATA;
            end else begin
              state_q <= scd_pkg::S_IGNORE;
            end
          end
        end
        scd_pkg::S_DATA: begin
          if (cnt_q != scd_pkg::CNT_MAX) begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        scd_pkg::S_IGNORE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pd_q <= scd_pkg::PD_RESET;
      int_q <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      cmd_err <= err_set;
      if (take && rx == scd_pkg::OP_WAKE) begin
        pd_q <= 1'b0;
      end else if (take && rx == scd_pkg::OP_SLEEP) begin
        pd_q <= 1'b1;
      end
      if (err_set) begin
        int_q <= 1'b1;
      end else if (take && rx == scd_pkg::OP_INT) begin
        int_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_valid <= 1'b0;
      cmd_code <= '0;
      cmd_arg_a <= '0;
      cmd_arg_b <= '0;
    end else begin
      cmd_valid <= 1'b0;
      if (take && rx inside {scd_pkg::OP_RECORD, scd_pkg::OP_STOP}) begin
        cmd_valid <= 1'b1;
        cmd_code <= rx;
        cmd_arg_a <= '0;
        cmd_arg_b <= '0;
      end else if (args_last && !bad_key && !is_cfg(op_q) &&
                   op_q != scd_pkg::OP_MEM_RD &&
                   op_q != scd_pkg::OP_MEM_WR) begin
        cmd_valid <= 1'b1;
        cmd_code <= op_q;
        cmd_arg_a <= full[23:0];
        cmd_arg_b <= '0;
        if (op_q == scd_pkg::OP_RANGE_ERASE) begin
          cmd_arg_a <= full[47:24];
          cmd_arg_b <= full[23:0];
        end else if (op_q == scd_pkg::OP_CHECKSUM) begin
          cmd_arg_a <= '0;
          cmd_arg_b <= full[23:0];
        end else if (op_q == scd_pkg::OP_MASS_ERASE) begin
          cmd_arg_a <= '0;
        end else if (op_q == scd_pkg::OP_MACRO) begin
          cmd_arg_a <= {8'h00, full[15:0]};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 1'b0;
      lo_q <= '0;
      sample_valid <= 1'b0;
      sample_data <= '0;
    end else begin
      sample_valid <= 1'b0;
      if (link.cs_n) begin
        phase_q <= 1'b0;
      end else if (in_data && op_q == scd_pkg::OP_SAMPLE) begin
        phase_q <= !phase_q;
        if (!phase_q) begin
          lo_q <= rx;
        end else begin
          sample_valid <= 1'b1;
          sample_data <= {rx, lo_q};
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ptr_q <= '0;
      acc_addr <= '0;
      acc_wdata <= '0;
      mem_re <= 1'b0;
      mem_we <= 1'b0;
      cfg_re <= 1'b0;
      cfg_we <= 1'b0;
    end else begin
      mem_re <= 1'b0;
      mem_we <= 1'b0;
      cfg_re <= 1'b0;
      cfg_we <= 1'b0;
      if (args_last) begin
        ptr_q <= full[23:0];
        if (is_cfg(op_q)) begin
          ptr_q <= {14'h0000, op_q[1:0], rx};
          acc_addr <= {14'h0000, op_q[1:0], rx};
          cfg_re <= cfg_rd(op_q);
          if (cfg_rd(op_q)) begin
            ptr_q <= {14'h0000, op_q[1:0], rx} + 24'h000001;
          end
        end else if (op_q == scd_pkg::OP_MEM_RD) begin
          acc_addr <= full[23:0];
          mem_re <= 1'b1;
          ptr_q <= full[23:0] + 24'h000001;
        end
      end else if (in_data && (op_q == scd_pkg::OP_MEM_RD ||
                               op_q == scd_pkg::OP_MEM_WR || is_cfg(op_q))) begin
        ptr_q <= ptr_q + 24'h000001;
        acc_addr <= ptr_q;
        acc_wdata <= rx;
        if (is_cfg(op_q)) begin
          acc_addr <= {14'h0000, ptr_q[scd_pkg::CFG_IDX_W-1:0]};
          cfg_re <= cfg_rd(op_q);
          cfg_we <= !cfg_rd(op_q);
        end else begin
          mem_re <= op_q == scd_pkg::OP_MEM_RD;
          mem_we <= op_q == scd_pkg::OP_MEM_WR;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_q <= '0;
    end else if (state_q != scd_pkg::S_DATA) begin
      tx_q <= '0;
    end else begin
      tx_q <= '0;
      if (op_q == scd_pkg::OP_STATUS || op_q == scd_pkg::OP_INT) begin
        tx_q <= snap_q;
      end else if (op_q == scd_pkg::OP_MSG_ADDR) begin
        case (cnt_q)
          3'h0: tx_q <= msg_addr[23:16];
          3'h1: tx_q <= msg_addr[15:8];
          3'h2: tx_q <= msg_addr[7:0];
          3'h3: tx_q <= sector_length[15:8];
          3'h4: tx_q <= sector_length[7:0];
          default: tx_q <= '0;
        endcase
      end else if (op_q == scd_pkg::OP_SECT_LEN) begin
        if (cnt_q == 3'h0) tx_q <= sector_length[15:8];
        if (cnt_q == 3'h1) tx_q <= sector_length[7:0];
      end else if (op_q == scd_pkg::OP_IDENT) begin
        if (cnt_q == 3'h0) tx_q <= ID_CODE[15:8];
        if (cnt_q == 3'h1) tx_q <= ID_CODE[7:0];
      end else if (op_q == scd_pkg::OP_MEM_RD) begin
        tx_q <= mem_rdata;
      end else if (cfg_rd(op_q)) begin
        tx_q <= cfg_rdata;
      end
    end
  end
endmodule

// ---- rtl/scd_host.sv ----
`timescale 1ns/1ps
module scd_host #(
  parameter int HALF = scd_pkg::SCLK_HALF // clk cycles per sclk half
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  scd_spi_if.host link, // serial link to device
  input wire logic req_valid, // byte offered
  input wire logic [7:0] req_data, // byte to send
  input wire logic req_last, // byte ends the frame
  output logic req_ready, // byte accepted
  output logic rsp_valid, // pulse: byte received
  output logic [7:0] rsp_data, // byte received
  output logic busy // frame in progress
);
  scd_pkg::scd_host_state_type state_q;
  logic [7:0] sh_q;
  logic [2:0] bits_q;
  logic [7:0] div_q;
  logic last_q, sclk_q, cs_n_q, tick;

  assign tick = div_q == 8'(HALF - 1);
  assign req_ready = state_q == scd_pkg::H_IDLE ||
                     state_q == scd_pkg::H_NEXT;
  assign busy = !cs_n_q;
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = sh_q[7];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_q <= '0;
    end else if (req_ready || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= scd_pkg::H_IDLE;
      sh_q <= '0;
      bits_q <= '0;
      last_q <= 1'b0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        scd_pkg::H_IDLE, scd_pkg::H_NEXT: begin
          if (req_valid) begin
            cs_n_q <= 1'b0;
            sh_q <= req_data;
            last_q <= req_last;
            bits_q <= '0;
            state_q <= scd_pkg::H_SHIFT;
          end
        end
        scd_pkg::H_SHIFT: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            // The device moves to its next bit right after it sees the rise.
            rsp_data <= {rsp_data[6:0], link.miso};
          end else if (tick) begin
            sclk_q <= 1'b0;
            sh_q <= {sh_q[6:0], 1'b0};
            bits_q <= bits_q + 3'h1;
            if (bits_q == scd_pkg::CNT_MAX) begin
              rsp_valid <= 1'b1;
              state_q <= last_q ? scd_pkg::H_TAIL : scd_pkg::H_NEXT;
            end
          end
        end
        scd_pkg::H_TAIL: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            state_q <= scd_pkg::H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ---- bench/scd_spi_props.sv ----
`timescale 1ns/1ps
module scd_spi_props (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic sclk, // link clock
  input wire logic cs_n, // frame select, active low
  input wire logic mosi, // host to device data
  input wire logic miso // device to host data
);
  logic sclk_q;
  logic cs_q;
  logic [7:0] rises_q;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
    end
  end

  // Counts link clock rises since the frame opened.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rises_q <= 8'h00;
    end else if (!cs_n && cs_q) begin
      rises_q <= 8'h00;
    end else if (sclk && !sclk_q) begin
      rises_q <= rises_q + 8'h01;
    end
  end

  sequence s_high_phase;
    sclk [*4] ##1 !sclk;
  endsequence

  sequence s_lead_in;
    !sclk [*3] ##[1:6] sclk;
  endsequence

  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("Link clock not low outside a frame.");
  a_high_phase_len: assert property ($rose(sclk) |-> s_high_phase)
    else $error("Link clock high phase has the wrong length.");
  a_low_phase_len: assert property ($fell(sclk) && !cs_n |-> !sclk [*4])
    else $error("Link clock low phase too short.");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("Host data moved while link clock high.");
  a_frame_lead: assert property ($fell(cs_n) |-> s_lead_in)
    else $error("First link clock edge misplaced in frame.");
  a_frame_bytes: assert property ($rose(cs_n) |->
    rises_q[2:0] == 3'h0 && rises_q != 8'h00)
    else $error("Frame did not carry whole bytes.");
  a_tail_gap: assert property ($rose(cs_n) |-> $past(sclk, 4) == 1'b0)
    else $error("Frame closed too soon after last clock.");
  a_min_frame: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("Frame select pulse too short.");
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] IDC = 16'hC3A5; // arbitrary value
  logic clk_sys = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_last = 1'b0;
  logic [7:0] req_data = 8'h00, mrd = 8'h00, crd = 8'h00, ccode, awd, rsp_data;
  logic req_ready, rsp_valid, busy, pd_o, int_o, cerr, cval;
  logic mre, mwe, cre, cwe, sv;
  logic rdy = 1'b1, full = 1'b0, mac = 1'b0, qf = 1'b0, bsy = 1'b0;
  logic [23:0] maddr = 24'h000000, ca, cb, aa;
  logic [15:0] slen = 16'h0000, sd;
  logic [63:0] ev[$], ex[$];
  logic [7:0] er[$], rq[$];
  logic [7:0] ops[10] = '{8'hB0, 8'h38, 8'h3C, 8'h2A, 8'hAA,
                          8'h40, 8'h46, 8'h42, 8'h44, 8'h48};
  int fail_count = 0, checked = 0, cyc = 0, rs;
  bit pd = 1'b1, intp = 1'b0;

  scd_spi_if i_scd_spi_if ();
  scd_host i_scd_host (.clk_sys(clk_sys), .rstn(rstn), .link(i_scd_spi_if),
    .req_valid(req_valid), .req_data(req_data), .req_last(req_last),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy));
  scd_device #(.ID_CODE(IDC)) i_scd_device (.clk_sys(clk_sys), .rstn(rstn),
    .link(i_scd_spi_if), .buffer_ready_flag(rdy), .memory_full_flag(full),
    .macro_busy_flag(mac), .queue_full_flag(qf), .command_busy_flag(bsy),
    .msg_addr(maddr), .sector_length(slen), .mem_rdata(mrd),
    .cfg_rdata(crd), .powered_down_flag(pd_o), .int_pending(int_o),
    .cmd_err(cerr), .cmd_valid(cval), .cmd_code(ccode), .cmd_arg_a(ca),
    .cmd_arg_b(cb), .acc_addr(aa), .acc_wdata(awd), .mem_re(mre),
    .mem_we(mwe), .cfg_re(cre), .cfg_we(cwe), .sample_valid(sv),
    .sample_data(sd));
  scd_spi_props i_scd_spi_props (.clk_sys(clk_sys), .rstn(rstn),
    .sclk(i_scd_spi_if.sclk), .cs_n(i_scd_spi_if.cs_n),
    .mosi(i_scd_spi_if.mosi), .miso(i_scd_spi_if.miso));

  always #2 clk_sys = ~clk_sys;

  function automatic logic [7:0] memf(logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] cfgf(logic [23:0] a);
    return a[7:0] + 8'h11;
  endfunction
  function automatic bit acc(logic [7:0] op, logic [7:0] s);
    case (op)
      8'hB0: return s[7:6] == 2'b01 && s[2:0] == 3'h0;
      8'h38: return s[7:6] == 2'b01 && !s[4] && s[2:1] == 2'h0;
      8'h3C: return s[7:6] == 2'b01 && s[2:1] == 2'h0;
      8'h2A, 8'hAA: return s[7:6] == 2'b01;
      8'h40, 8'h42, 8'h44, 8'h46, 8'h48, 8'h10, 8'h12: return 1'b1;
      default: return !s[7];
    endcase
  endfunction

  task automatic end_sim;
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_b(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_ev(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Reference model of one frame: fills expected events and replies.
  task automatic model(input logic [7:0] q[$]);
    logic [7:0] op, s;
    logic [23:0] a;
    logic [9:0] ix;
    op = q[0];
    s = {pd, rdy, intp, full, 1'b0, mac, qf, bsy};
    a = {q[1], q[2], q[3]};
    ix = {op[1:0], q[1]};
    er = {};
    rs = 1;
    if (!acc(op, s) || (op == 8'h26 && q[1] != 8'h01)) begin
      ex.push_back({8'h2, 56'h0});
      intp = 1'b1;
    end else casez (op)
      8'h40: er = {s};
      8'h46: begin
        er = {s};
        intp = 1'b0;
      end
      8'h42: er = {maddr[23:16], maddr[15:8], maddr[7:0], slen[15:8], slen[7:0]};
      8'h44: er = {slen[15:8], slen[7:0]};
      8'h48: er = {IDC[15:8], IDC[7:0]};
      8'hA2: begin
        rs = 4;
        er = {memf(a), memf(a + 24'h1)};
      end
      8'hA0: for (int i = 4; i < q.size(); i++)
        ex.push_back({8'h3, q[i], a + 24'(i - 4), 24'h0});
      8'h24: ex.push_back({8'h1, op, a, q[4], q[5], q[6]});
      8'hF2: ex.push_back({8'h1, op, 24'h0, a});
      8'h26, 8'h38, 8'h2A: ex.push_back({8'h1, op, 48'h0});
      8'hB0: ex.push_back({8'h1, op, 8'h0, q[1], q[2], 24'h0});
      8'h3C: ex.push_back({8'h1, op, a, 24'h0});
      8'hAA: for (int i = 1; i + 1 < q.size(); i += 2)
        ex.push_back({8'h5, 16'h0, q[i + 1], q[i], 24'h0});
      8'h10: pd = 1'b0;
      8'h12: pd = 1'b1;
      8'b100000??: for (int i = 2; i < q.size(); i++)
        ex.push_back({8'h4, q[i], 14'h0, ix + 10'(i - 2), 24'h0});
      8'b100100??: begin
        rs = 2;
        for (int i = 2; i < q.size(); i++)
          er.push_back(cfgf({14'h0, ix + 10'(i - 2)}));
      end
      default: ;
    endcase
  endtask

  task automatic xfer(input logic [7:0] b, input bit last,
                      output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req_data = b;
    req_last = last;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 200) fail_count++;
    r = rsp_data;
  endtask

  task automatic frame(input logic [7:0] q[$]);
    logic [7:0] r;
    model(q);
    rq = {};
    foreach (q[i]) begin
      xfer(q[i], i == q.size() - 1, r);
      rq.push_back(r);
    end
    repeat (20) @(posedge clk_sys);
    #1;
    foreach (er[i]) cmp_b(rq[rs + i], er[i]); // replies
    cmp_ev(64'(ev.size()), 64'(ex.size())); // event count
    while (ex.size() > 0 && ev.size() > 0)
      cmp_ev(ev.pop_front(), ex.pop_front()); // events
    ev = {};
    ex = {};
    cmp_b({6'h0, pd_o, int_o}, {6'h0, pd, intp}); // flags
  endtask

  always @(posedge clk_sys) begin
    if (cval === 1'b1) ev.push_back({8'h1, ccode, ca, cb});
    if (cerr === 1'b1) ev.push_back({8'h2, 56'h0});
    if (mwe === 1'b1) ev.push_back({8'h3, awd, aa, 24'h0});
    if (cwe === 1'b1) ev.push_back({8'h4, awd, aa, 24'h0});
    if (sv === 1'b1) ev.push_back({8'h5, 16'h0, sd, 24'h0});
    if (mre === 1'b1) mrd <= #1 memf(aa);
    if (cre === 1'b1) crd <= #1 cfgf(aa);
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      end_sim;
    end
  end

  initial begin
    logic [7:0] q[$];
    void'($urandom(32'h90d6));
    repeat (12) @(posedge clk_sys);
    #1 rstn = 1'b1;
    cmp_b({6'h0, pd_o, int_o}, 8'h02); // reset state
    frame('{8'h40, 8'h00}); // asleep status
    frame('{8'hA0, 8'h00, 8'h00, 8'h01, 8'h07}); // refused
    frame('{8'h46, 8'h00}); // query asleep
    frame('{8'h10}); // wake
    for (int k = 0; k < 50; k++) begin
      rdy = ($urandom % 4) != 0;
      {full, mac, qf, bsy} = 4'($urandom) & 4'($urandom);
      maddr = 24'($urandom);
      slen = 16'($urandom);
      q = {ops[k % 10]};
      repeat (5) q.push_back(8'($urandom));
      frame(q); // gating
    end
    frame('{8'hA0, 8'h12, 8'h34, 8'hFF, 8'hA5, 8'h3C}); // write
    frame('{8'hA2, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00}); // read
    frame('{8'h24, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h0C});
    frame('{8'hF2, 8'h0F, 8'h00, 8'h01}); // checksum
    frame('{8'h26, 8'h02}); // wrong key
    frame('{8'h26, 8'h01}); // mass erase
    frame('{8'h83, 8'hFE, 8'h11, 8'h22, 8'h33}); // index wrap
    frame('{8'h93, 8'hFF, 8'h00, 8'h00}); // config read
    frame('{8'h12}); // sleep
    frame('{8'h38, 8'h00}); // refused asleep
    frame('{8'h46, 8'h00}); // clears flag
    end_sim;
  end
endmodule
